//--- logic/rpsc_map.vh
/*
 * constants for the reset pin state controller: cycle counts around reset
 * assumes one core clock (P) drives the block; memory-clock (E) periods
 * are taken as a fixed multiple of P
 */
`ifndef RPSC_MAP_VH
`define RPSC_MAP_VH

// ==========================================
// clock relations
`define RPSC_E_PER_P 4
// ==========================================
// timing counts in CPU (P) and memory (E) clock periods
`define RPSC_ZV_MIN_P 2
`define RPSC_VALID_MAX_P 16070
// P counts are plain numbers so they can follow a size prefix in the logic;
// keep each one equal to its E count times RPSC_E_PER_P (plus the 3P terms)
`define RPSC_EMIFZ_MIN_E 16
`define RPSC_EMIFZ_MIN_P 64
`define RPSC_ECKO_HZ_MIN_E 2
`define RPSC_ECKO_HZ_P 8
`define RPSC_EMIFZ_HZ_P 19
`define RPSC_ECKI_SYNC_P 83
`define RPSC_CNT_W 15
// ==========================================
// group encodings of the eeprom pins
`define RPSC_GRP_Z 1'b0
`define RPSC_GRP_LOW 1'b1

`endif

//--- logic/rpsc_counter.v
/*
 * saturating cycle counter, cleared while its clear input is high
 * assumes a synchronous active-high clear
 */
`timescale 1ns/1ns
module rpsc_counter (
	// clock and clear
	input wire clk_i,
	input wire clear_i,
	// count value
	output reg [14:0] count_o
);
	// ==========================================
	// counting
	// saturate rather than wrap so a long wait never re-triggers early thresholds
	always @(posedge clk_i) begin
		if (clear_i) begin
			count_o <= 15'h0000;
		end else if (count_o != 15'h7fff) begin
			count_o <= count_o + 15'h0001;
		end
	end
endmodule // rpsc_counter

//--- logic/rpsc_top.v
/*
 * reset pin state controller: drives the enables of each pin group around
 * reset, and captures the boot straps while reset is held
 * assumes reset_n_i synchronous to clk_i; straps and selects are valid levels
 */
`timescale 1ns/1ns
`include "rpsc_map.vh"

// Functional notes
// - memory Z group floats within 3P+4E after reset asserts
// - memory Z group stays floating at least 16E, valid by 16070P after release
// - peripheral Z group floats immediately, valid 2P to 16070P after release
// - hold ack follows hold request during reset; bus requests held low
// - eeprom pins are low group only with PCI on and serial port 2 off
// - memory clock out floats no sooner than 2E, valid by 16070P after release
// - memory input clock resynchronised within 3P+20E assert, 16070P release
// - halfword select joins peripheral Z group only in 16-bit host mode
module rpsc_top (
	// clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// external reset pin and configuration pins
	input wire reset_n_i,
	input wire pci_enable_i,
	input wire serial_port2_select_i,
	input wire host_port_16bit_i,
	input wire [1:0] bus_hold_req_i,
	input wire [11:0] secondary_mem_address_i,
	input wire host_data_bit5_i,
	// memory interface enables
	output reg ext_mem_z_oe_o,
	output reg ext_mem_clock_out1_oe_o,
	output reg ext_mem_clock_in_sync_o,
	// hold and request outputs
	output reg [1:0] bus_hold_ack_o,
	output reg [1:0] bus_hold_ack_oe_o,
	output reg [1:0] ext_bus_request_out_o,
	// peripheral enables
	output reg periph_z_oe_o,
	output reg halfword_select_oe_o,
	output reg eeprom_chip_select_o,
	output reg eeprom_chip_select_oe_o,
	output reg eeprom_clock_oe_o,
	output reg eeprom_data_out_oe_o,
	output reg eeprom_low_group_o,
	// captured configuration
	output reg [11:0] boot_config_o,
	output reg boot_host_bit5_o,
	output reg pci_enable_o
);
	// ==========================================
	// phases
	localparam PH_RUN = 2'b00;
	localparam PH_ASSERT = 2'b01;
	localparam PH_HELD = 2'b10;
	localparam PH_RELEASE = 2'b11;

	reg [1:0] phase;
	reg [1:0] next_phase;
	reg in_reset;
	wire [14:0] count;
	wire count_clear;
	wire eeprom_low;
	// threshold hits; sync_off_due, periph_on_due and memz_on_due true on the edge at which their interval has elapsed
	wire count_fresh;
	wire memz_off_due;
	wire clkout_off_due;
	wire sync_off_due;
	wire periph_on_due;
	wire memz_on_due;

	// one counter serves both edges: cleared on every reset pin transition
	assign count_clear = sys_rst_i | (reset_n_i == in_reset);

	rpsc_counter u_count (
		.clk_i(clk_i),
		.clear_i(count_clear),
		.count_o(count)
	);

	// eeprom pins move between low and Z groups on the live select levels
	function grp_low;
		input pci_en;
		input sp2_sel;
		begin
			grp_low = pci_en & ~sp2_sel;
		end
	endfunction

	assign eeprom_low = grp_low(pci_enable_i, serial_port2_select_i);

	// ==========================================
	// elapsed-time decode
	// the counter reads n-1 on the n-th edge after a pin change; on the change
	// edge itself it still holds the previous interval, so that edge never counts
	function reached;
		input fresh;
		input [14:0] cnt;
		input [14:0] thr;
		begin
			reached = fresh & (cnt >= thr);
		end
	endfunction

	assign count_fresh = ~count_clear;
	assign memz_off_due = reached(count_fresh, count, 15'd`RPSC_EMIFZ_HZ_P - 15'd2);
	assign clkout_off_due = reached(count_fresh, count, 15'd`RPSC_ECKO_HZ_P);
	assign sync_off_due = reached(count_fresh, count, 15'd`RPSC_ECKI_SYNC_P - 15'd1);
	assign periph_on_due = reached(count_fresh, count, 15'd`RPSC_ZV_MIN_P - 15'd1);
	assign memz_on_due = reached(count_fresh, count, 15'd`RPSC_EMIFZ_MIN_P - 15'd1);

	// ==========================================
	// phase sequencing
	always @* begin
		next_phase = phase;
		case (phase)
			PH_RUN: begin
				if (!reset_n_i) begin
					next_phase = PH_ASSERT;
				end
			end
			PH_ASSERT: begin
				if (reset_n_i) begin
					next_phase = PH_RELEASE;
				end else if (count >= 15'd`RPSC_ECKI_SYNC_P) begin
					next_phase = PH_HELD;
				end
			end
			PH_HELD: begin
				if (reset_n_i) begin
					next_phase = PH_RELEASE;
				end
			end
			PH_RELEASE: begin
				if (!reset_n_i) begin
					next_phase = PH_ASSERT;
				end else if (count >= 15'd`RPSC_EMIFZ_MIN_P) begin
					next_phase = PH_RUN;
				end
			end
			default: begin
				next_phase = PH_ASSERT;
			end
		endcase
	end

	// ==========================================
	// state and pin enables
	// enables come straight from flops so pins never glitch on decode
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			phase <= PH_ASSERT;
			in_reset <= 1'b1;
			ext_mem_z_oe_o <= 1'b0;
			ext_mem_clock_out1_oe_o <= 1'b0;
			ext_mem_clock_in_sync_o <= 1'b0;
			bus_hold_ack_o <= 2'b00;
			bus_hold_ack_oe_o <= 2'b00;
			ext_bus_request_out_o <= 2'b00;
			periph_z_oe_o <= 1'b0;
			halfword_select_oe_o <= 1'b0;
			eeprom_chip_select_o <= 1'b0;
			eeprom_chip_select_oe_o <= 1'b0;
			eeprom_clock_oe_o <= 1'b0;
			eeprom_data_out_oe_o <= 1'b0;
			eeprom_low_group_o <= `RPSC_GRP_Z;
			boot_config_o <= 12'h000;
			boot_host_bit5_o <= 1'b0;
			pci_enable_o <= 1'b0;
		end else begin
			phase <= next_phase;
			in_reset <= ~reset_n_i;
			eeprom_low_group_o <= eeprom_low ? `RPSC_GRP_LOW : `RPSC_GRP_Z;
			if (!reset_n_i) begin
				// peripheral Z group floats on the first edge seen low
				periph_z_oe_o <= 1'b0;
				halfword_select_oe_o <= 1'b0;
				// memory Z group off inside the 3P+4E limit
				if (memz_off_due || phase != PH_RUN) begin
					ext_mem_z_oe_o <= 1'b0;
				end
				// memory clock out keeps running for at least 2E
				if (clkout_off_due) begin
					ext_mem_clock_out1_oe_o <= 1'b0;
				end
				// input clock sync drops at the 3P+20E mark
				if (sync_off_due) begin
					ext_mem_clock_in_sync_o <= 1'b0;
				end
				// hold ack mirrors hold request; bus requests low
				bus_hold_ack_o <= bus_hold_req_i;
				bus_hold_ack_oe_o <= 2'b11;
				ext_bus_request_out_o <= 2'b00;
				// eeprom pins: driven low in low group, else floated
				eeprom_chip_select_o <= 1'b0;
				eeprom_chip_select_oe_o <= eeprom_low;
				eeprom_clock_oe_o <= eeprom_low;
				eeprom_data_out_oe_o <= eeprom_low;
				// straps captured every cycle reset is held, last value kept
				boot_config_o <= secondary_mem_address_i;
				boot_host_bit5_o <= host_data_bit5_i;
				pci_enable_o <= pci_enable_i;
			end else begin
				// release: clocks and peripherals well inside 16070P
				ext_mem_clock_in_sync_o <= 1'b1;
				ext_mem_clock_out1_oe_o <= 1'b1;
				if (periph_on_due) begin
					periph_z_oe_o <= 1'b1;
					halfword_select_oe_o <= host_port_16bit_i;
				end
				// memory Z group waits the 16E floor before driving
				if (memz_on_due) begin
					ext_mem_z_oe_o <= 1'b1;
				end
				bus_hold_ack_oe_o <= 2'b11;
				eeprom_chip_select_oe_o <= eeprom_low;
				eeprom_clock_oe_o <= 1'b1;
				eeprom_data_out_oe_o <= 1'b1;
				eeprom_chip_select_o <= 1'b1;
			end
		end
	end
endmodule // rpsc_top

//--- bench/rpsc_chk_sva.sv
/* rpsc_chk: timing checks on the pin group enables around reset
   assumes the ports of rpsc_top, one clock */
`timescale 1ns/1ns
module rpsc_chk (
	// clock and resets
	input wire clk_i,
	input wire sys_rst_i,
	input wire reset_n_i,
	// selects
	input wire pci_enable_i,
	input wire serial_port2_select_i,
	input wire [1:0] bus_hold_req_i,
	// enables
	input wire ext_mem_z_oe_o,
	input wire ext_mem_clock_out1_oe_o,
	input wire ext_mem_clock_in_sync_o,
	input wire periph_z_oe_o,
	input wire [1:0] bus_hold_ack_o,
	input wire [1:0] ext_bus_request_out_o,
	input wire eeprom_low_group_o
);
// ====
// edges seen released; saturates so it never wraps back into range
int hi_cnt = 0;
always @(posedge clk_i) begin
	if (sys_rst_i || !reset_n_i) hi_cnt <= 0;
	else if (hi_cnt < 20000) hi_cnt <= hi_cnt + 1;
end
default clocking @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
a_memz_float: assert property ($fell(reset_n_i) |-> ##[1:19] !ext_mem_z_oe_o)
	else $error("memory group still driven");
a_memz_hold: assert property (reset_n_i && ext_mem_z_oe_o |-> hi_cnt >= 64)
	else $error("memory group driven too early");
a_valid_bound: assert property (hi_cnt == 16070 |-> ext_mem_z_oe_o && periph_z_oe_o
	&& ext_mem_clock_out1_oe_o && ext_mem_clock_in_sync_o)
	else $error("group not valid in time");
a_periph_float: assert property (!reset_n_i |=> !periph_z_oe_o)
	else $error("peripheral group driven in reset");
a_periph_min: assert property (reset_n_i && periph_z_oe_o |-> hi_cnt >= 2)
	else $error("peripheral group driven too early");
a_clkout_late: assert property ($fell(reset_n_i) && ext_mem_clock_out1_oe_o
	|=> ext_mem_clock_out1_oe_o [*7])
	else $error("clock out floated too soon");
a_sync_drop: assert property ($fell(reset_n_i) |-> ##[1:84] !ext_mem_clock_in_sync_o)
	else $error("input clock not resynchronised");
a_hold_follow: assert property (!reset_n_i && !$past(reset_n_i) && !$past(sys_rst_i, 2)
	|-> bus_hold_ack_o == $past(bus_hold_req_i) && ext_bus_request_out_o == 2'h0)
	else $error("hold ack or request wrong in reset");
a_eeprom_group: assert property (!$past(sys_rst_i, 2) |-> eeprom_low_group_o ==
	($past(pci_enable_i) && !$past(serial_port2_select_i)))
	else $error("eeprom group wrong");
endmodule // rpsc_chk
bind rpsc_top rpsc_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_n_i(reset_n_i),
	.pci_enable_i(pci_enable_i), .serial_port2_select_i(serial_port2_select_i),
	.bus_hold_req_i(bus_hold_req_i), .ext_mem_z_oe_o(ext_mem_z_oe_o),
	.ext_mem_clock_out1_oe_o(ext_mem_clock_out1_oe_o),
	.ext_mem_clock_in_sync_o(ext_mem_clock_in_sync_o), .periph_z_oe_o(periph_z_oe_o),
	.bus_hold_ack_o(bus_hold_ack_o), .ext_bus_request_out_o(ext_bus_request_out_o),
	.eeprom_low_group_o(eeprom_low_group_o));

//--- bench/rpsc_board.sv
/* rpsc_board: board reset and strap driver
   assumes the bench raises hold_i to hold the device in reset */
`timescale 1ns/1ns
module rpsc_board (
	// clock and command
	input wire clk_i,
	input wire hold_i,
	input wire [12:0] strap_i,
	// pins
	output reg reset_n_o = 1'b0,
	output reg [12:0] pins_o = 13'h0
);
// ====
// straps only while reset held; toggling after so stale values never pass
always @(posedge clk_i) begin
	reset_n_o <= !hold_i;
	pins_o <= hold_i ? strap_i : ~pins_o;
end
endmodule // rpsc_board

//--- bench/tb.sv
/* tb: drives the board model and selects, checks the group enables
   assumes rpsc_top with its full 16070-cycle release window */
`timescale 1ns/1ns
module tb;
reg clk_i = 1'b0;
reg sys_rst_i = 1'b1;
reg hold = 1'b1;
reg pci = 1'b1;
reg sp2 = 1'b0;
reg hp16 = 1'b1;
reg [1:0] hreq = 2'h0;
reg [12:0] strap = 13'h1a5c;
wire rst_n, memz, ck1, cki, per, hws, eeg, b5;
wire ecs, ecs_oe, eck_oe, edo_oe, pcio;
wire [1:0] hack, hack_oe, breq;
wire [12:0] pins;
wire [11:0] boot;
int n_errors = 0;
int checks = 0;
int cyc = 0;
initial forever #50 clk_i = ~clk_i;
rpsc_board u_board (.clk_i(clk_i), .hold_i(hold), .strap_i(strap), .reset_n_o(rst_n),
	.pins_o(pins));
rpsc_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_n_i(rst_n),
	.pci_enable_i(pci), .serial_port2_select_i(sp2), .host_port_16bit_i(hp16),
	.bus_hold_req_i(hreq), .secondary_mem_address_i(pins[11:0]), .host_data_bit5_i(pins[12]),
	.ext_mem_z_oe_o(memz), .ext_mem_clock_out1_oe_o(ck1), .ext_mem_clock_in_sync_o(cki),
	.bus_hold_ack_o(hack), .bus_hold_ack_oe_o(hack_oe), .ext_bus_request_out_o(breq),
	.periph_z_oe_o(per), .halfword_select_oe_o(hws), .eeprom_chip_select_o(ecs),
	.eeprom_chip_select_oe_o(ecs_oe), .eeprom_clock_oe_o(eck_oe),
	.eeprom_data_out_oe_o(edo_oe), .eeprom_low_group_o(eeg), .boot_config_o(boot),
	.boot_host_bit5_o(b5), .pci_enable_o(pcio));
// ====
// shared compare, wait and closing tasks
task chk(input logic [12:0] got, input logic [12:0] exp);
	checks++;
	if (got !== exp) begin
		n_errors++;
		$display("BAD %0t got %h exp %h", $time, got, exp);
	end
endtask
task w(input int n);
	repeat (n) @(posedge clk_i);
endtask
task print_verdict;
	$display("n_errors %0d checks %0d", n_errors, checks);
	if (n_errors == 0 && checks > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
// cut a hang short well past the longest release window
always @(posedge clk_i) begin
	cyc++;
	if (cyc > 20000) begin
		n_errors++;
		print_verdict;
	end
end
// ====
// reset held: both serial port 2 selects with PCI on, then release, then a second reset
initial begin
	w(16);
	sys_rst_i <= 1'b0;
	for (int i = 0; i < 4; i++) begin
		w(4);
		sp2 <= i[0];
		hreq <= i[1:0];
		w(3);
		@(negedge clk_i);
		chk(eeg, pci & ~sp2);
		chk({ecs, ecs_oe, eck_oe, edo_oe}, {1'b0, {3{pci & ~sp2}}});
		chk(hack, hreq);
		chk({hack_oe, breq}, 4'hc);
		chk({memz, per, hws, ck1, cki}, 5'h00);
	end
	chk({b5, boot}, strap);
	chk(pcio, pci);
	w(1);
	hold <= 1'b0;
	w(40);
	sp2 <= 1'b0;
	hp16 <= 1'b0;
	@(negedge clk_i);
	chk(memz, 1'b0);
	chk({ck1, cki, per}, 3'h7);
	chk(hws, 1'b1);
	chk({ecs, eck_oe, edo_oe}, 3'h7);
	chk({b5, boot}, strap);
	w(3);
	@(negedge clk_i);
	chk(eeg, 1'b1);
	chk(ecs_oe, 1'b1);
	chk(hws, 1'b0);
	w(16070);
	@(negedge clk_i);
	chk(memz, 1'b1);
	w(1);
	hold <= 1'b1;
	w(3);
	@(negedge clk_i);
	chk(per, 1'b0);
	chk(ck1, 1'b1);
	w(20);
	@(negedge clk_i);
	chk(memz, 1'b0);
	chk(ck1, 1'b0);
	w(70);
	@(negedge clk_i);
	chk(cki, 1'b0);
	// pci enable only moves while the whole device is held in system reset
	w(1);
	sys_rst_i <= 1'b1;
	pci <= 1'b0;
	w(16);
	sys_rst_i <= 1'b0;
	w(4);
	@(negedge clk_i);
	chk({eeg, ecs_oe, eck_oe, edo_oe}, 4'h0);
	chk(pcio, 1'b0);
	print_verdict;
end
endmodule // tb
